// ---- logic/smcg_top.sv ----
// Purpose: Sleep-mode clock gating bank with Wishbone access and interrupt.
// Assumes: Power state, run and deep-sleep banks come from same-clock logic.
// Notes:   Applied enables lag a change of state or bank by one cycle.
//
// Register access is over Wishbone, each request acknowledged one cycle later.
`timescale 1ns/1ps
module smcg_top (
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic                cyc_i,
   input  wire logic                stb_i,
   input  wire logic                we_i,
   input  wire logic [31:0]         adr_i,
   input  wire logic [31:0]         dat_i,
   input  wire logic [3:0]          sel_i,
   output logic [31:0]              dat_o,
   output logic                     ack_o,
   input  wire smcg_pkg::smcg_pwr_e pwr_mode_i,
   input  wire logic                auto_gating_enable_i,
   input  wire logic [31:0]         run_clock_gate_bank_1_i,
   input  wire logic [31:0]         deep_sleep_clock_gate_bank_1_i,
   input  wire logic [31:0]         unit_access_i,
   output logic [31:0]              unit_clk_o,
   output logic [31:0]              unit_clk_en_o,
   output logic                     bus_fault_o,
   output logic                     irq_o
);
   import smcg_pkg::*;

   smcg_gate_if gif ();

   smcg_bus_e         bus_state_r;
   logic [31:0]       sleep_bank_r;
   logic [31:0]       eff_r;
   logic [31:0]       eff_nxt;
   logic              sleep_act_r;
   logic              sleep_act_nxt;
   logic [IRQ_W-1:0]  stat_r;
   logic [IRQ_W-1:0]  stat_nxt;
   logic [IRQ_W-1:0]  ien_r;
   logic [IRQ_W-1:0]  ien_nxt;
   logic [IRQ_W-1:0]  events;
   logic [IRQ_W-1:0]  clr_bits;
   logic              req;
   logic              wr_take;
   logic [31:0]       rd_nxt;

   // ---------------------------------------------------------------
   // Wishbone handshake
   // ---------------------------------------------------------------
   // A request is acknowledged one cycle after it is seen. The write is
   // committed at the acknowledging edge, as the master expects.
   assign req     = cyc_i & stb_i;
   assign wr_take = (bus_state_r == BUS_ACK) & req & we_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_state_r <= BUS_IDLE;
      end else begin
         case (bus_state_r)
            BUS_IDLE: begin
               if (req) begin
                  bus_state_r <= BUS_ACK;
               end
            end
            BUS_ACK:  bus_state_r <= BUS_IDLE;
            default:  bus_state_r <= BUS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= (bus_state_r == BUS_IDLE) & req;
      end
   end

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   // Unmapped offsets answer with zero rather than an error, so a probe
   // of a neighbouring bank never hangs the bus.
   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (smcg_hit(adr_i, SLEEP_OFF)) begin
         rd_nxt = sleep_bank_r & IMPL_MASK;
      end else if (smcg_hit(adr_i, EFF_OFF)) begin
         rd_nxt = eff_r;
      end else if (smcg_hit(adr_i, INT_STAT_OFF)) begin
         rd_nxt = {{(32-IRQ_W){1'b0}}, stat_r};
      end else if (smcg_hit(adr_i, INT_EN_OFF)) begin
         rd_nxt = {{(32-IRQ_W){1'b0}}, ien_r};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if ((bus_state_r == BUS_IDLE) && req && !we_i) begin
         dat_o <= rd_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Sleep gating bank
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sleep_bank_r <= SLEEP_RESET;
      end else if (wr_take && smcg_hit(adr_i, SLEEP_OFF)) begin
         // Only unit bits can be stored; the rest stay zero.
         sleep_bank_r <= smcg_merge(sleep_bank_r, dat_i, sel_i)
                         & IMPL_MASK;
      end
   end

   // ---------------------------------------------------------------
   // Applied enables
   // ---------------------------------------------------------------
   // Without automatic gating the run bank rules in every state.
   always_comb begin
      eff_nxt       = run_clock_gate_bank_1_i;
      sleep_act_nxt = 1'b0;
      if (auto_gating_enable_i) begin
         case (pwr_mode_i)
            PWR_SLEEP: begin
               eff_nxt       = sleep_bank_r;
               sleep_act_nxt = 1'b1;
            end
            PWR_DEEP: eff_nxt = deep_sleep_clock_gate_bank_1_i;
            PWR_RUN:  eff_nxt = run_clock_gate_bank_1_i;
            default:  eff_nxt = run_clock_gate_bank_1_i;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         eff_r       <= SLEEP_RESET;
         sleep_act_r <= 1'b0;
      end else begin
         eff_r       <= eff_nxt & IMPL_MASK;
         sleep_act_r <= sleep_act_nxt;
      end
   end

   assign gif.eff_en      = eff_r;
   assign gif.unit_access = unit_access_i;
   assign unit_clk_en_o   = eff_r;
   assign bus_fault_o     = gif.fault;

   smcg_clk_gate u_gate (
      .clk_i  (clk_i),
      .gif    (gif),
      .gclk_o (unit_clk_o)
   );

   smcg_fault_chk u_fault (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .gif   (gif)
   );

   // ---------------------------------------------------------------
   // Interrupts
   // ---------------------------------------------------------------
   // A new event in the same cycle as its clear is kept: set wins.
   always_comb begin
      events                = '0;
      events[IRQ_FAULT_BIT] = gif.fault;
      events[IRQ_ENTER_BIT] = sleep_act_nxt & ~sleep_act_r;
      clr_bits              = '0;
      if (wr_take && smcg_hit(adr_i, INT_CLR_OFF) && sel_i[0]) begin
         clr_bits = dat_i[IRQ_W-1:0];
      end
      stat_nxt = (stat_r & ~clr_bits) | events;
      ien_nxt  = ien_r;
      if (wr_take && smcg_hit(adr_i, INT_EN_OFF) && sel_i[0]) begin
         ien_nxt = dat_i[IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat_r <= IRQ_RESET;
         ien_r  <= IRQ_RESET;
         irq_o  <= 1'b0;
      end else begin
         stat_r <= stat_nxt;
         ien_r  <= ien_nxt;
         irq_o  <= |(stat_nxt & ien_nxt);
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // The edge that first sees reset low is not disabled, so the checks of the
   // deep-sleep and run banks under auto gating also ask for reset low.

   a_reset_bank_zero: assert property (
      @(posedge clk_i) disable iff (1'b0)
      rst_i |=> (sleep_bank_r == SLEEP_RESET) && !ack_o)
      else $error("sleep bank not zero after reset");

   a_reset_gates_off: assert property (
      @(posedge clk_i) disable iff (1'b0)
      rst_i |=> (unit_clk_en_o == SLEEP_RESET) && !irq_o && !bus_fault_o)
      else $error("unit enables not off after reset");

   a_reserved_read_zero: assert property (
      (req && !we_i && (bus_state_r == BUS_IDLE)
       && smcg_hit(adr_i, SLEEP_OFF))
      |=> ack_o && ((dat_o & ~IMPL_MASK) == 32'h0000_0000))
      else $error("reserved sleep bank bits read nonzero");

   a_read_returns_bank: assert property (
      (req && !we_i && (bus_state_r == BUS_IDLE)
       && smcg_hit(adr_i, SLEEP_OFF))
      |=> dat_o == $past(sleep_bank_r))
      else $error("sleep bank read returned wrong value");

   a_read_data_holds: assert property (
      !(req && !we_i && (bus_state_r == BUS_IDLE)) |=> $stable(dat_o))
      else $error("read data changed without a read");

   a_write_lands: assert property (
      (wr_take && smcg_hit(adr_i, SLEEP_OFF) && (sel_i == 4'hF))
      |=> sleep_bank_r == ($past(dat_i) & IMPL_MASK))
      else $error("full write to sleep bank did not land");

   a_other_write_keeps: assert property (
      (wr_take && !smcg_hit(adr_i, SLEEP_OFF))
      |=> $stable(sleep_bank_r))
      else $error("sleep bank changed by another register write");

   a_sleep_applies: assert property (
      (auto_gating_enable_i && (pwr_mode_i == PWR_SLEEP))
      |=> eff_r == $past(sleep_bank_r))
      else $error("sleep bank not applied in sleep");

   a_deep_applies: assert property (
      (!rst_i && auto_gating_enable_i && (pwr_mode_i == PWR_DEEP))
      |=> eff_r == ($past(deep_sleep_clock_gate_bank_1_i) & IMPL_MASK))
      else $error("deep-sleep bank not applied in deep sleep");

   a_run_applies: assert property (
      (!rst_i && auto_gating_enable_i && (pwr_mode_i == PWR_RUN))
      |=> eff_r == ($past(run_clock_gate_bank_1_i) & IMPL_MASK))
      else $error("run bank not applied in run");

   a_no_auto_run: assert property (
      !auto_gating_enable_i
      |=> eff_r == ($past(run_clock_gate_bank_1_i) & IMPL_MASK))
      else $error("run bank not applied without auto gating");

   a_no_sleep_flag: assert property (
      !auto_gating_enable_i |=> !sleep_act_r)
      else $error("sleep state flagged without auto gating");

   a_one_bit_each: assert property (
      (unit_clk_en_o & ~IMPL_MASK) == 32'h0000_0000)
      else $error("enable raised for a bit with no unit");

   a_ack_single: assert property (ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");

   a_ack_answers: assert property (
      (req && (bus_state_r == BUS_IDLE)) |=> ack_o)
      else $error("request not acknowledged in one cycle");

   a_fault_sticky: assert property (
      gif.fault |=> stat_r[IRQ_FAULT_BIT])
      else $error("fault event not captured in status");

   a_enter_sticky: assert property (
      events[IRQ_ENTER_BIT] |=> stat_r[IRQ_ENTER_BIT])
      else $error("sleep entry event not captured in status");

   a_clear_drops: assert property (
      (wr_take && smcg_hit(adr_i, INT_CLR_OFF) && sel_i[0]
       && dat_i[IRQ_FAULT_BIT] && !gif.fault)
      |=> !stat_r[IRQ_FAULT_BIT])
      else $error("fault status not cleared by write of one");

   a_enable_write: assert property (
      (wr_take && smcg_hit(adr_i, INT_EN_OFF) && sel_i[0])
      |=> ien_r == $past(dat_i[IRQ_W-1:0]))
      else $error("interrupt enable write did not land");

   a_irq_level: assert property (
      irq_o == |(stat_r & ien_r))
      else $error("interrupt does not follow enabled status");

   // ---------------------------------------------------------------
   // Coverage
   // ---------------------------------------------------------------
   c_sleep_write: cover property (wr_take && smcg_hit(adr_i, SLEEP_OFF));
   c_enter_sleep: cover property (events[IRQ_ENTER_BIT] ##1 irq_o);
   c_fault_seen:  cover property (!bus_fault_o ##1 bus_fault_o);
   c_deep_mode:   cover property (auto_gating_enable_i
                                  && (pwr_mode_i == PWR_DEEP));
   c_clear_write: cover property (wr_take && smcg_hit(adr_i, INT_CLR_OFF));

endmodule : smcg_top

// ---- logic/smcg_pkg.sv ----
// Purpose: Constants, types and helpers of the sleep-mode clock gating bank.
// Assumes: One system clock, synchronous active-high reset, Wishbone slave.
// Notes:   Offsets are byte addresses within the system control window.
package smcg_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int          ADR_W        = 12;
   localparam logic [11:0] SLEEP_OFF    = 12'h114;
   localparam logic [11:0] EFF_OFF      = 12'h180;
   localparam logic [11:0] INT_STAT_OFF = 12'h184;
   localparam logic [11:0] INT_CLR_OFF  = 12'h188;
   localparam logic [11:0] INT_EN_OFF   = 12'h18C;
   localparam logic [31:0] SLEEP_RESET  = 32'h0000_0000;

   // ---------------------------------------------------------------
   // Gating bit positions
   // ---------------------------------------------------------------
   localparam int COMPARATOR_2_BIT  = 26;
   localparam int COMPARATOR_1_BIT  = 25;
   localparam int COMPARATOR_0_BIT  = 24;
   localparam int GP_TIMER_3_BIT    = 19;
   localparam int GP_TIMER_2_BIT    = 18;
   localparam int GP_TIMER_1_BIT    = 17;
   localparam int GP_TIMER_0_BIT    = 16;
   localparam int TWO_WIRE_0_BIT    = 12;
   localparam int SYNC_SERIAL_0_BIT = 4;
   localparam int ASYNC_SERIAL_1_BIT = 1;
   localparam int ASYNC_SERIAL_0_BIT = 0;

   localparam logic [31:0] ONE = 32'h0000_0001;
   localparam logic [31:0] IMPL_MASK =
      (ONE << COMPARATOR_2_BIT) | (ONE << COMPARATOR_1_BIT) |
      (ONE << COMPARATOR_0_BIT) | (ONE << GP_TIMER_3_BIT) |
      (ONE << GP_TIMER_2_BIT)   | (ONE << GP_TIMER_1_BIT) |
      (ONE << GP_TIMER_0_BIT)   | (ONE << TWO_WIRE_0_BIT) |
      (ONE << SYNC_SERIAL_0_BIT) | (ONE << ASYNC_SERIAL_1_BIT) |
      (ONE << ASYNC_SERIAL_0_BIT);

   // ---------------------------------------------------------------
   // Interrupt layout
   // ---------------------------------------------------------------
   localparam int          IRQ_W         = 2;
   localparam int          IRQ_FAULT_BIT = 0;
   localparam int          IRQ_ENTER_BIT = 1;
   localparam logic [1:0]  IRQ_RESET     = 2'h0;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_DEEP} smcg_pwr_e;
   typedef enum logic {BUS_IDLE, BUS_ACK} smcg_bus_e;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic smcg_hit(input logic [31:0] adr,
                                     input logic [11:0] off);
      smcg_hit = (adr[ADR_W-1:2] == off[ADR_W-1:2]);
   endfunction : smcg_hit

   function automatic logic [31:0] smcg_merge(input logic [31:0] old,
                                              input logic [31:0] wdat,
                                              input logic [3:0]  sel);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = wdat[b*8 +: 8];
         end
      end
      smcg_merge = res;
   endfunction : smcg_merge

endpackage : smcg_pkg

// ---- logic/smcg_gate_if.sv ----
// Purpose: Carries applied enables, unit access strobes and fault flag.
// Assumes: All signals on the system clock.
// Notes:   The top drives enables and accesses, the checker the fault.
`timescale 1ns/1ps
interface smcg_gate_if;
   logic [31:0] eff_en;
   logic [31:0] unit_access;
   logic        fault;

   modport ctrl (output eff_en, output unit_access, input fault);
   modport chk  (input eff_en, input unit_access, output fault);
   modport gate (input eff_en);
endinterface : smcg_gate_if

// ---- logic/smcg_clk_gate.sv ----
// Purpose: Glitch-free clock gates, one for each implemented unit.
// Assumes: Enables change only just after a rising clock edge.
// Notes:   Latch is transparent while the clock is low.
`timescale 1ns/1ps
module smcg_clk_gate (
   input  wire logic  clk_i,
   smcg_gate_if.gate  gif,
   output logic [31:0] gclk_o
);
   import smcg_pkg::*;

   logic [31:0] en_lat;

   // ---------------------------------------------------------------
   // Gating latches
   // ---------------------------------------------------------------
   // The latch holds the enable across the high phase, so a change of
   // enable never clips a clock pulse.
   always_latch begin
      if (!clk_i) begin
         en_lat = gif.eff_en & IMPL_MASK;
      end
   end

   assign gclk_o = {32{clk_i}} & en_lat;

endmodule : smcg_clk_gate

// ---- logic/smcg_fault_chk.sv ----
// Purpose: Flags any access to a unit whose clock is gated off.
// Assumes: unit_access is a one-hot level from the interconnect.
// Notes:   Fault is registered, one cycle after the offending access.
`timescale 1ns/1ps
module smcg_fault_chk (
   input  wire logic clk_i,
   input  wire logic rst_i,
   smcg_gate_if.chk  gif
);
   import smcg_pkg::*;

   logic [31:0] blocked;

   assign blocked = gif.unit_access & ~gif.eff_en & IMPL_MASK;

   // ---------------------------------------------------------------
   // Fault flag
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gif.fault <= 1'b0;
      end else begin
         gif.fault <= |blocked;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_fault_on_gated: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (blocked != 32'h0000_0000) |=> gif.fault)
      else $error("access to gated unit did not fault");

   a_no_fault_open: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (blocked == 32'h0000_0000) |=> !gif.fault)
      else $error("fault raised for a clocked unit");

endmodule : smcg_fault_chk

// ---- dv/smcg_top_tb_top.sv ----
// Purpose: Self-checking bench for the sleep-mode clock gating bank.
// Assumes: Classic Wishbone master, one clock, fixed random seed.
// Notes:   The bench keeps its own copy of the sleep bank to predict reads.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("unexpected %s exp=%h got=%h", nm, e, g); end end
module smcg_top_tb_top;
   import smcg_pkg::*;

   // ---------------------------------------------------------------
   // Stimulus and observation
   // ---------------------------------------------------------------
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i = 1'b0;
   logic [31:0] adr_i = 32'h0;
   logic [31:0] dat_i = 32'h0;
   logic [3:0]  sel_i = 4'h0;
   smcg_pwr_e   pwr_mode_i = PWR_RUN;
   logic        auto_i = 1'b0;
   logic [31:0] run_i = 32'h0;
   logic [31:0] deep_i = 32'h0;
   logic [31:0] acc_i = 32'h0;
   logic [31:0] dat_o;
   logic        ack_o;
   logic [31:0] unit_clk_o;
   logic [31:0] unit_clk_en_o;
   logic        bus_fault_o;
   logic        irq_o;
   int          error_cnt = 0;
   int          n_checks = 0;
   int          cyc_cnt = 0;
   logic [31:0] sl_m = 32'h0;
   logic [31:0] q;
   int          pos [11] = '{26, 25, 24, 19, 18, 17, 16, 12, 4, 1, 0};

   always #10 clk_i = ~clk_i;

   smcg_top u_smcg_top (
      .clk_i                          (clk_i),
      .rst_i                          (rst_i),
      .cyc_i                          (cyc_i),
      .stb_i                          (stb_i),
      .we_i                           (we_i),
      .adr_i                          (adr_i),
      .dat_i                          (dat_i),
      .sel_i                          (sel_i),
      .dat_o                          (dat_o),
      .ack_o                          (ack_o),
      .pwr_mode_i                     (pwr_mode_i),
      .auto_gating_enable_i           (auto_i),
      .run_clock_gate_bank_1_i        (run_i),
      .deep_sleep_clock_gate_bank_1_i (deep_i),
      .unit_access_i                  (acc_i),
      .unit_clk_o                     (unit_clk_o),
      .unit_clk_en_o                  (unit_clk_en_o),
      .bus_fault_o                    (bus_fault_o),
      .irq_o                          (irq_o)
   );

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] bmerge(input logic [31:0] o,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            o[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return o;
   endfunction : bmerge

   function automatic logic [31:0] exp_en(input logic [1:0] m,
                                          input logic a);
      if (a && m == 2'h1) begin
         return sl_m & IMPL_MASK;
      end
      if (a && m == 2'h2) begin
         return deep_i & IMPL_MASK;
      end
      return run_i & IMPL_MASK;
   endfunction : exp_en

   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop

   // The request is held until the edge at which ack is sampled high.
   task automatic wb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {20'h0, a};
      dat_i <= d;
      sel_i <= s;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask : wb

   task automatic wr_sleep(input logic [31:0] d, input logic [3:0] s);
      wb(1'b1, SLEEP_OFF, d, s);
      sl_m = bmerge(sl_m, d, s) & IMPL_MASK;
   endtask : wr_sleep

   // Checks applied enables, the gated clocks in both phases, and a fault.
   task automatic chk_gate(input logic [31:0] hit);
      logic [31:0] en;
      repeat (3) @(posedge clk_i);
      en = exp_en(pwr_mode_i, auto_i);
      `CHK("enable", en, unit_clk_en_o)
      #5;
      `CHK("clk_hi", en, unit_clk_o)
      #10;
      `CHK("clk_lo", 32'h0, unit_clk_o)
      @(posedge clk_i);
      acc_i <= hit;
      @(posedge clk_i);
      acc_i <= 32'h0;
      @(posedge clk_i);
      `CHK("fault", |(hit & IMPL_MASK & ~en), bus_fault_o)
   endtask : chk_gate

   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt > 20000) begin
         error_cnt++;
         report_and_stop();
      end
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(96));
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, SLEEP_OFF, 32'h0, 4'hF);
      `CHK("sleep_rst", SLEEP_RESET, q)
      wb(1'b0, EFF_OFF, 32'h0, 4'hF);
      `CHK("eff_rst", 32'h0, q)
      wr_sleep(32'hFFFF_FFFF, 4'hF);
      wb(1'b0, SLEEP_OFF, 32'h0, 4'hF);
      `CHK("sleep_all", IMPL_MASK, q)
      pwr_mode_i <= PWR_SLEEP;
      auto_i <= 1'b1;
      run_i <= 32'hFFFF_FFFF;
      for (int i = 0; i < 11; i++) begin
         wr_sleep(32'h1 << pos[i], 4'hF);
         wb(1'b0, SLEEP_OFF, 32'h0, 4'hF);
         `CHK("sleep_bit", 32'h1 << pos[i], q)
         chk_gate(32'h1 << pos[(i + 1) % 11]);
      end
      for (int i = 0; i < 24; i++) begin
         pwr_mode_i <= smcg_pwr_e'($urandom_range(3));
         auto_i <= 1'($urandom_range(1));
         run_i <= $urandom();
         deep_i <= $urandom();
         wr_sleep($urandom(), 4'($urandom()));
         wb(1'b0, SLEEP_OFF, 32'h0, 4'hF);
         `CHK("sleep_rd", sl_m, q)
         wb(1'b0, EFF_OFF, 32'h0, 4'hF);
         `CHK("eff_rd", exp_en(pwr_mode_i, auto_i), q)
         chk_gate(32'h1 << pos[$urandom_range(10)]);
      end
      wb(1'b1, 12'h200, 32'hFFFF_FFFF, 4'hF);
      wb(1'b0, 12'h200, 32'h0, 4'hF);
      `CHK("unmapped", 32'h0, q)
      wb(1'b0, INT_CLR_OFF, 32'h0, 4'hF);
      `CHK("clr_rd", 32'h0, q)
      pwr_mode_i <= PWR_RUN;
      auto_i <= 1'b0;
      run_i <= 32'h0;
      wb(1'b1, INT_EN_OFF, 32'h3, 4'h1);
      wb(1'b1, INT_CLR_OFF, 32'h3, 4'h1);
      repeat (3) @(posedge clk_i);
      `CHK("irq_idle", 1'b0, irq_o)
      chk_gate(32'h0001_0000);
      repeat (3) @(posedge clk_i);
      wb(1'b0, INT_STAT_OFF, 32'h0, 4'hF);
      `CHK("stat_fault", 32'h1, q)
      `CHK("irq_fault", 1'b1, irq_o)
      wb(1'b1, INT_EN_OFF, 32'h2, 4'h1);
      wb(1'b0, INT_EN_OFF, 32'h0, 4'hF);
      `CHK("ien_rd", 32'h2, q)
      repeat (3) @(posedge clk_i);
      `CHK("irq_mask", 1'b0, irq_o)
      wb(1'b1, INT_CLR_OFF, 32'h1, 4'h1);
      wb(1'b0, INT_STAT_OFF, 32'h0, 4'hF);
      `CHK("stat_clr", 32'h0, q)
      pwr_mode_i <= PWR_SLEEP;
      auto_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      `CHK("irq_enter", 1'b1, irq_o)
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      sl_m = 32'h0;
      wb(1'b0, SLEEP_OFF, 32'h0, 4'hF);
      `CHK("sleep_rst2", 32'h0, q)
      `CHK("irq_rst2", 1'b0, irq_o)
      chk_gate(32'h0000_0010);
      report_and_stop();
   end
endmodule : smcg_top_tb_top
